// File: ppc_pad_model.sv
// Pad model: driven level, else the pull level, else a floating toggle.
`timescale 1ns/10ps
module ppc_pad_model
  import ppc_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Outside drivers and pulls.
  input wire logic [NUM_PINS-1:0] drive_en,
  input wire logic [NUM_PINS-1:0] drive_val,
  input wire logic [NUM_PINS-1:0] pull_enable,
  input wire logic [NUM_PINS-1:0] pull_select,
  // Pad level.
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_q = '0;

  // A floating pin toggles so the simulator cannot settle it quietly.
  always @(posedge clock) begin
    float_q <= ~float_q;
  end

  // Level resolution per pin.
  always_comb begin
    pin_in = (drive_en & drive_val) | (~drive_en & pull_enable & pull_select) | (~drive_en & ~pull_enable & float_q);
  end
endmodule

// File: ppc_pin_filter.sv
// Synchroniser with optional digital glitch filter for one pin input.
`timescale 1ns/10ps
module ppc_pin_filter
  import ppc_pkg::*;
#(
  parameter int FILTER_LEN = GLITCH_LEN,
  parameter bit HAS_FILTER = 1'b0
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Pin level and filter control.
  input wire logic pin_in,
  input wire logic filter_en,
  // Cleaned level.
  output logic level_out
);

  // Refuse lengths that the four-bit counter cannot count.
  if (FILTER_LEN < 1 || FILTER_LEN > 15) begin : g_bad_len
    $error("ppc_pin_filter: FILTER_LEN out of range");
  end

  logic meta_q;
  logic sync_q;
  logic [3:0] stable_cnt_q;
  logic level_q;

  // Two flops bring the asynchronous pin into the clock domain.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // A new level is accepted only after it has held for FILTER_LEN cycles.
  always_ff @(posedge clock) begin
    if (rst) begin
      stable_cnt_q <= 4'h0;
      level_q <= 1'b1;
    end else if (!HAS_FILTER || !filter_en || sync_q == level_q) begin
      stable_cnt_q <= 4'h0;
      level_q <= sync_q;
    end else if (stable_cnt_q == 4'(FILTER_LEN - 1)) begin
      stable_cnt_q <= 4'h0;
      level_q <= sync_q;
    end else begin
      stable_cnt_q <= stable_cnt_q + 4'h1;
    end
  end

  assign level_out = level_q;

endmodule

// File: ppc_pkg.sv
// Package with sizes, reset defaults and function codes for the port pin control block.
package ppc_pkg;

  // Port geometry.
  localparam int NUM_PORTS = 5;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam int MUX_W = 3;
  localparam int PIN_W = 6;

  // Port indices within the flat pin vector, pin = port * 8 + bit.
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;

  // Function multiplexer codes.
  localparam logic [MUX_W-1:0] FUNCTION_SELECT_ZERO = 3'h0;
  localparam logic [MUX_W-1:0] FUNCTION_SELECT_SEVEN = 3'h7;

  // Per-pin reset defaults: pins A4, A5, C4, D3 are special.
  // C4 pulls down, so its select bit is clear although its pull is enabled.
  localparam logic [NUM_PINS-1:0] PULL_SELECT_RESET = 40'h00_0800_0030;
  localparam logic [NUM_PINS-1:0] PULL_ENABLE_RESET = 40'h00_0810_0030;
  localparam logic [NUM_PINS-1:0] MUX_SEVEN_RESET = 40'h00_0810_0030;

  // Passive filter exists on A5 and D3; only A5 starts enabled.
  localparam logic [NUM_PINS-1:0] FILTER_PRESENT = 40'h00_0800_0020;
  localparam logic [NUM_PINS-1:0] FILTER_RESET = 40'h00_0000_0020;

  // Drive strength exists on B4, B5, D0, D1, E0, E1; all start off.
  localparam logic [NUM_PINS-1:0] DRIVE_PRESENT = 40'h03_0300_3000;
  localparam logic [NUM_PINS-1:0] DRIVE_RESET = 40'h00_0000_0000;

  // Open drain starts off everywhere.
  localparam logic [NUM_PINS-1:0] OPEN_DRAIN_RESET = 40'h00_0000_0000;

  // Glitch filter exists on port E only.
  localparam logic [NUM_PORTS-1:0] GLITCH_PORT_PRESENT = 5'h10;
  localparam int GLITCH_LEN = 3;

  // Safety monitor input: default polarity is active low (polarity bit clear).
  localparam logic MONITOR_POLARITY_RESET = 1'b0;

endpackage

// File: ppc_port_control.sv
// Per-pin port control for five ports: pulls, filters, open drain, drive, mux, lock, requests.
`timescale 1ns/10ps
module ppc_port_control
  import ppc_pkg::*;
#(
  parameter int FILTER_LEN = GLITCH_LEN
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Configuration write port, one pin per write.
  input wire logic cfg_write,
  input wire logic [PIN_W-1:0] cfg_pin,
  input wire logic cfg_pull_select,
  input wire logic cfg_pull_enable,
  input wire logic cfg_passive_filter,
  input wire logic cfg_open_drain,
  input wire logic cfg_drive_strength,
  input wire logic [MUX_W-1:0] cfg_mux,
  input wire logic [1:0] cfg_request_mode,
  input wire logic cfg_lock,
  // Per-pin capability: pin carries I2C or UART transmit on the selected function.
  input wire logic [NUM_PINS-1:0] open_drain_capable,
  // Per-pin non-maskable interrupt function code and port E glitch filter enable.
  input wire logic [NUM_PINS-1:0] nmi_function_here,
  input wire logic [MUX_W-1:0] nmi_function_code,
  input wire logic glitch_filter_enable,
  // Pin levels from the pads.
  input wire logic [NUM_PINS-1:0] pin_in,
  // Safety monitor control and input.
  input wire logic monitor_input_polarity,
  input wire logic safety_monitor_input,
  // Request flag clear, one bit per pin.
  input wire logic [NUM_PINS-1:0] request_clear,
  // Pad controls.
  output logic [NUM_PINS-1:0] pull_select,
  output logic [NUM_PINS-1:0] pull_enable,
  output logic [NUM_PINS-1:0] passive_filter,
  output logic [NUM_PINS-1:0] open_drain,
  output logic [NUM_PINS-1:0] drive_strength,
  output logic [NUM_PINS*MUX_W-1:0] mux_select,
  output logic [NUM_PINS-1:0] lock_state,
  // Filtered input levels.
  output logic [NUM_PINS-1:0] pin_level,
  // Requests.
  output logic [NUM_PINS-1:0] request_flag,
  output logic [NUM_PORTS-1:0] port_irq,
  output logic [NUM_PORTS-1:0] port_dma,
  output logic nmi_request,
  output logic safety_monitor_fault
);

  // Request modes: off, interrupt on falling edge, interrupt on rising edge, DMA on any edge.
  // Off is the reset mode, so no pin raises a request until software asks for one.
  typedef enum logic [1:0] {
    PPC_REQ_OFF = 2'b00,
    PPC_REQ_IRQ_FALL = 2'b01,
    PPC_REQ_IRQ_RISE = 2'b10,
    PPC_REQ_DMA_EDGE = 2'b11
  } ppc_req_t;

  // Configuration registers, one bit or one field per pin.
  logic [NUM_PINS-1:0] pull_select_q;
  logic [NUM_PINS-1:0] pull_enable_q;
  logic [NUM_PINS-1:0] passive_filter_q;
  logic [NUM_PINS-1:0] open_drain_q;
  logic [NUM_PINS-1:0] drive_strength_q;
  logic [MUX_W-1:0] mux_q [NUM_PINS];
  ppc_req_t req_mode_q [NUM_PINS];
  logic [NUM_PINS-1:0] lock_q;

  // Input path and request state.
  logic [NUM_PINS-1:0] level_prev_q;
  logic [NUM_PINS-1:0] request_q;
  logic [NUM_PINS-1:0] request_is_dma;
  logic [NUM_PINS-1:0] nmi_hit;
  logic [NUM_PINS-1:0] level;

  // Safety monitor and non-maskable interrupt state.
  logic mon_meta_q;
  logic mon_sync_q;
  logic nmi_q;
  logic fault_q;

  // Refuse parameter values that the logic cannot serve.
  if (FILTER_LEN < 1 || FILTER_LEN > 15) begin : g_bad_filter_len
    $error("ppc_port_control: FILTER_LEN must lie between 1 and 15");
  end

  // Every pin must be reachable through the pin index of the write port.
  if (NUM_PINS > (1 << PIN_W)) begin : g_bad_pin_w
    $error("ppc_port_control: PIN_W is too narrow for NUM_PINS");
  end

  // The flat pin vector must hold exactly the pins of all ports.
  if (NUM_PINS != NUM_PORTS * PINS_PER_PORT) begin : g_bad_geometry
    $error("ppc_port_control: NUM_PINS does not match the port geometry");
  end

  // One genvar serves both the per-pin and the per-port loops.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      localparam bit PORT_E_PIN = GLITCH_PORT_PRESENT[gi / PINS_PER_PORT];
      logic hit;
      logic rise;
      logic fall;
      logic evt;

      // A write lands only on its own, unlocked pin; indices past the last pin match nothing.
      assign hit = cfg_write && (cfg_pin == PIN_W'(gi)) && !lock_q[gi];

      // Pull select and pull enable take their pin-specific reset values.
      // The direction bit only matters while the pull is enabled, so it is stored on every pin.
      always_ff @(posedge clock) begin
        if (rst) begin
          pull_select_q[gi] <= PULL_SELECT_RESET[gi];
          pull_enable_q[gi] <= PULL_ENABLE_RESET[gi];
        end else if (hit) begin
          pull_select_q[gi] <= cfg_pull_select;
          pull_enable_q[gi] <= cfg_pull_enable;
        end
      end

      // Passive filter bits exist only where present; elsewhere they are tied off.
      // Writes to pins without the filter are dropped, so their bit keeps its reset value of zero.
      always_ff @(posedge clock) begin
        if (rst) begin
          passive_filter_q[gi] <= FILTER_RESET[gi];
        end else if (hit && FILTER_PRESENT[gi]) begin
          passive_filter_q[gi] <= cfg_passive_filter;
        end
      end

      // The open-drain bit is stored on every pin so software may set it before changing function.
      // The output gate further down keeps it from acting unless an I2C or UART transmit function is selected.
      always_ff @(posedge clock) begin
        if (rst) begin
          open_drain_q[gi] <= OPEN_DRAIN_RESET[gi];
        end else if (hit) begin
          open_drain_q[gi] <= cfg_open_drain;
        end
      end

      // Drive strength enable, only on the six pins that carry it.
      // Elsewhere the write is dropped and the output gate ties the bit low as well.
      always_ff @(posedge clock) begin
        if (rst) begin
          drive_strength_q[gi] <= DRIVE_RESET[gi];
        end else if (hit && DRIVE_PRESENT[gi]) begin
          drive_strength_q[gi] <= cfg_drive_strength;
        end
      end

      // Function mux and request mode; a mode change does not clear a flag already raised.
      // Any code is accepted; which peripheral a code reaches is decided outside this block.
      always_ff @(posedge clock) begin
        if (rst) begin
          mux_q[gi] <= MUX_SEVEN_RESET[gi] ? FUNCTION_SELECT_SEVEN : FUNCTION_SELECT_ZERO;
          req_mode_q[gi] <= PPC_REQ_OFF;
        end else if (hit) begin
          mux_q[gi] <= cfg_mux;
          req_mode_q[gi] <= ppc_req_t'(cfg_request_mode);
        end
      end

      // Lock bit is write-once: once set, only reset clears it and freezes the pin.
      // The write that sets the lock still applies its other fields; later writes are all ignored.
      always_ff @(posedge clock) begin
        if (rst) begin
          lock_q[gi] <= 1'b0;
        end else if (hit && cfg_lock) begin
          lock_q[gi] <= 1'b1;
        end
      end

      // Input path; the glitch filter is built only for port E pins.
      // Pins of ports A to D ignore glitch_filter_enable and pay only the three-flop delay of synchroniser and level register.
      ppc_pin_filter #(
        .FILTER_LEN(FILTER_LEN),
        .HAS_FILTER(PORT_E_PIN)
      ) u_filter (
        .clock(clock),
        .rst(rst),
        .pin_in(pin_in[gi]),
        .filter_en(glitch_filter_enable),
        .level_out(level[gi])
      );

      // Edges are taken from the cleaned level, so a glitch removed on port E raises nothing.
      assign rise = level[gi] && !level_prev_q[gi];
      assign fall = !level[gi] && level_prev_q[gi];

      // Edge detection for requests.
      // The previous level resets high, matching an idle pin, so reset itself makes no edge.
      always_comb begin
        case (req_mode_q[gi])
          PPC_REQ_OFF: evt = 1'b0;
          PPC_REQ_IRQ_FALL: evt = fall;
          PPC_REQ_IRQ_RISE: evt = rise;
          PPC_REQ_DMA_EDGE: evt = rise || fall;
          default: evt = 1'b0;
        endcase
      end

      // A pin in DMA mode feeds its port's DMA line and never its interrupt line.
      assign request_is_dma[gi] = (req_mode_q[gi] == PPC_REQ_DMA_EDGE);

      // Sticky request flag; a new event wins over a clear in the same cycle.
      // Letting the event win means an edge that meets a clear is never lost.
      always_ff @(posedge clock) begin
        if (rst) begin
          level_prev_q[gi] <= 1'b1;
          request_q[gi] <= 1'b0;
        end else begin
          level_prev_q[gi] <= level[gi];
          if (evt) begin
            request_q[gi] <= 1'b1;
          end else if (request_clear[gi]) begin
            request_q[gi] <= 1'b0;
          end
        end
      end

      // Low level counts only while the pin has the non-maskable interrupt function.
      // The level is read after the synchroniser, so the request never sees a metastable value.
      assign nmi_hit[gi] = nmi_function_here[gi] && (mux_q[gi] == nmi_function_code) && !level[gi];

      // Each pin owns one MUX_W-bit field of the flat mux vector, lowest pin first.
      assign mux_select[gi*MUX_W +: MUX_W] = mux_q[gi];
    end
  endgenerate

  // Per-port request outputs, split by interrupt or DMA use.
  // Both lines are levels that stand until software clears every flag that feeds them.
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      logic [PINS_PER_PORT-1:0] port_req;
      logic [PINS_PER_PORT-1:0] port_is_dma;

      // The flags and modes of this port's pins.
      assign port_req = request_q[gi*PINS_PER_PORT +: PINS_PER_PORT];
      assign port_is_dma = request_is_dma[gi*PINS_PER_PORT +: PINS_PER_PORT];

      // Each port raises an interrupt and a DMA request line of its own.
      assign port_irq[gi] = |(port_req & ~port_is_dma);
      assign port_dma[gi] = |(port_req & port_is_dma);
    end
  endgenerate

  // Non-maskable interrupt is registered so the output is glitch free.
  // The flop costs one cycle of latency, which is small beside the synchroniser delay.
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= |nmi_hit;
    end
  end

  // Safety monitor input is synchronised, then compared against the active polarity.
  // The flops reset high, the idle level of an active-low input, so with polarity clear no fault shows right after reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      mon_meta_q <= 1'b1;
      mon_sync_q <= 1'b1;
    end else begin
      mon_meta_q <= safety_monitor_input;
      mon_sync_q <= mon_meta_q;
    end
  end

  // Polarity clear means a low input signals the fault; set inverts that.
  // The polarity bit comes from logic on this clock and needs no synchroniser.
  always_ff @(posedge clock) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (mon_sync_q == monitor_input_polarity);
    end
  end

  // Pad controls; open drain is gated by the function so a stale enable cannot leak.
  // Pull outputs come straight from their registers; software owns their meaning on every pin.
  assign pull_select = pull_select_q;
  assign pull_enable = pull_enable_q;
  assign passive_filter = passive_filter_q & FILTER_PRESENT;
  assign open_drain = open_drain_q & open_drain_capable;
  assign drive_strength = drive_strength_q & DRIVE_PRESENT;
  assign lock_state = lock_q;
  assign pin_level = level;
  assign request_flag = request_q;
  assign nmi_request = nmi_q;
  assign safety_monitor_fault = fault_q;

endmodule

// File: ppc_port_control_properties.sv
// Checker with concurrent properties for the port pin control block.
`timescale 1ns/10ps
module ppc_checker
  import ppc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Inputs seen at the pins.
  input wire logic [NUM_PINS-1:0] pin_level,
  input wire logic [NUM_PINS-1:0] nmi_function_here,
  input wire logic [NUM_PINS-1:0] open_drain_capable,
  input wire logic safety_monitor_input,
  input wire logic monitor_input_polarity,
  // Pad controls and requests.
  input wire logic [NUM_PINS-1:0] pull_select,
  input wire logic [NUM_PINS-1:0] pull_enable,
  input wire logic [NUM_PINS-1:0] passive_filter,
  input wire logic [NUM_PINS-1:0] open_drain,
  input wire logic [NUM_PINS-1:0] drive_strength,
  input wire logic [NUM_PINS*MUX_W-1:0] mux_select,
  input wire logic [NUM_PORTS-1:0] port_irq,
  input wire logic nmi_request,
  input wire logic safety_monitor_fault
);
  // Boot pins A4, A5, C4, D3 start on function seven; written out here, not taken from the package.
  function automatic logic [NUM_PINS*MUX_W-1:0] mux_boot();
    logic [NUM_PINS*MUX_W-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_PINS; i++) m[i*3 +: 3] = (i == 4 || i == 5 || i == 20 || i == 27) ? 3'h7 : 3'h0;
    return m;
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_pull_dir_reset: assert property ($past(rst) |-> pull_select == 40'h00_0800_0030)
    else $error("pull select off its reset value");
  a_pull_en_reset: assert property ($past(rst) |-> pull_enable == 40'h00_0810_0030)
    else $error("pull enable off its reset value");
  a_filter_two_pins: assert property ((passive_filter & ~40'h00_0800_0020) == '0)
    else $error("passive filter on a pin without one");
  a_filter_reset: assert property ($past(rst) |-> passive_filter == 40'h00_0000_0020)
    else $error("passive filter off its reset value");
  a_drain_gated: assert property ((open_drain & ~open_drain_capable) == '0)
    else $error("open drain on an incapable function");
  a_drain_reset: assert property ($past(rst) |-> open_drain == '0)
    else $error("open drain set after reset");
  a_drive_six_pins: assert property ((drive_strength & ~40'h03_0300_3000) == '0)
    else $error("drive strength on a pin without one");
  a_drive_reset: assert property ($past(rst) |-> drive_strength == '0)
    else $error("drive strength set after reset");
  a_mux_reset: assert property ($past(rst) |-> mux_select == mux_boot())
    else $error("mux off its reset value");
  a_nmi_needs_low: assert property (&(pin_level | ~nmi_function_here) |=> !nmi_request)
    else $error("nmi without a low pin");
  a_monitor_level: assert property ($stable({safety_monitor_input, monitor_input_polarity})[*5] |->
    safety_monitor_fault == (safety_monitor_input == monitor_input_polarity))
    else $error("monitor fault disagrees with polarity");

  c_nmi: cover property (nmi_request);
  c_fault: cover property (safety_monitor_fault);
  c_irq: cover property (|port_irq);
endmodule

bind ppc_port_control ppc_checker chk_u (
  .clock(clock),
  .rst(rst),
  .pin_level(pin_level),
  .nmi_function_here(nmi_function_here),
  .open_drain_capable(open_drain_capable),
  .safety_monitor_input(safety_monitor_input),
  .monitor_input_polarity(monitor_input_polarity),
  .pull_select(pull_select),
  .pull_enable(pull_enable),
  .passive_filter(passive_filter),
  .open_drain(open_drain),
  .drive_strength(drive_strength),
  .mux_select(mux_select),
  .port_irq(port_irq),
  .nmi_request(nmi_request),
  .safety_monitor_fault(safety_monitor_fault)
);

// File: ppc_port_control_test.sv
// Self-checking testbench for the port pin control block.
`timescale 1ns/10ps
module ppc_port_control_test;
  import ppc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr_en, c_ps, c_pe, c_pf, c_od, c_ds, c_lk, gf_en, pol, mon_in, nmi, fault;
  logic [5:0] c_pin;
  logic [2:0] c_mux, nmi_code;
  logic [1:0] c_mode;
  logic [4:0] irq, dma;
  logic [39:0] od_cap, nmi_here, clr, drv_en, drv_val, pin_in, ps, pe, pf, od, ds, lk, lvl, rf;
  logic [119:0] mux;
  int bad_count = 0;
  int total_checks = 0;

  ppc_port_control dut_u (.clock(clock), .rst(rst), .cfg_write(wr_en), .cfg_pin(c_pin), .cfg_pull_select(c_ps),
    .cfg_pull_enable(c_pe), .cfg_passive_filter(c_pf), .cfg_open_drain(c_od), .cfg_drive_strength(c_ds),
    .cfg_mux(c_mux), .cfg_request_mode(c_mode), .cfg_lock(c_lk), .open_drain_capable(od_cap),
    .nmi_function_here(nmi_here), .nmi_function_code(nmi_code), .glitch_filter_enable(gf_en), .pin_in(pin_in),
    .monitor_input_polarity(pol), .safety_monitor_input(mon_in), .request_clear(clr), .pull_select(ps),
    .pull_enable(pe), .passive_filter(pf), .open_drain(od), .drive_strength(ds), .mux_select(mux),
    .lock_state(lk), .pin_level(lvl), .request_flag(rf), .port_irq(irq), .port_dma(dma), .nmi_request(nmi),
    .safety_monitor_fault(fault));
  ppc_pad_model pad_u (.clock(clock), .drive_en(drv_en), .drive_val(drv_val), .pull_enable(pe),
    .pull_select(ps), .pin_in(pin_in));

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  task automatic chk(input logic [119:0] g, input logic [119:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Inputs always move 1 ns after the edge, never on it.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // One pin write; an idle edge follows so the strobe is never re-raised in the same step.
  task automatic wr(input int p, input logic [2:0] m, input logic [1:0] md, input logic [5:0] f);
    c_pin = p[5:0];
    c_mux = m;
    c_mode = md;
    {c_ps, c_pe, c_pf, c_od, c_ds, c_lk} = f;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic t_reset();
    logic [119:0] m;
    m = '0;
    for (int i = 0; i < 40; i++) if (i == 4 || i == 5 || i == 20 || i == 27) m[3*i +: 3] = 3'h7;
    chk(ps, 40'h00_0800_0030);
    chk(pe, 40'h00_0810_0030);
    chk(pf, 40'h00_0000_0020);
    chk(od, '0);
    chk(ds, '0);
    chk(mux, m);
    // Released C4 must follow its reset pull-down through the pad model.
    drv_en[20] = 1'b0;
    cyc(4);
    chk(lvl[20], 1'b0);
    drv_en[20] = 1'b1;
    $display("test reset done");
  endtask

  // Every pin asks for passive filter, open drain and drive strength; only capable pins may show them.
  task automatic t_caps();
    od_cap = 40'h80_0000_000C;
    for (int i = 0; i < 40; i++) wr(i, 3'h0, 2'h0, 6'b001110);
    chk(pf, 40'h00_0800_0020);
    chk(ds, 40'h03_0300_3000);
    chk(od, od_cap);
    chk(ps, '0);
    chk(pe, '0);
    od_cap = '0;
    cyc(1);
    chk(od, '0);
    $display("test caps done");
  endtask

  task automatic t_nmi();
    nmi_here = 40'h1 << 27;
    nmi_code = 3'h7;
    wr(27, 3'h7, 2'h0, 6'h0);
    drv_val[27] = 1'b0;
    cyc(6);
    chk(nmi, 1'b1);
    wr(27, 3'h0, 2'h0, 6'h0);
    cyc(3);
    chk(nmi, 1'b0);
    drv_val[27] = 1'b1;
    $display("test nmi done");
  endtask

  task automatic t_mon();
    logic [2:0] tab [4] = '{3'b001, 3'b010, 3'b111, 3'b100};
    for (int i = 0; i < 4; i++) begin
      {pol, mon_in} = tab[i][2:1];
      cyc(6);
      chk(fault, tab[i][0]);
    end
    $display("test monitor done");
  endtask

  // Falling edge raises an interrupt, rising edge in mode 3 a DMA request, on each port.
  task automatic t_req();
    for (int p = 0; p < 5; p++) begin
      wr(p*8+6, 3'h1, 2'h1, 6'h0);
      drv_val[p*8+6] = 1'b0;
      cyc(6);
      chk(irq, 5'h1 << p);
      chk(rf, 40'h1 << (p*8+6));
      clr = '1;
      cyc(2);
      clr = '0;
      chk(irq, '0);
      wr(p*8+6, 3'h1, 2'h3, 6'h0);
      // Clear held across the event edge: the event must still win for one cycle.
      clr = '1;
      drv_val[p*8+6] = 1'b1;
      cyc(4);
      chk(dma, 5'h1 << p);
      cyc(1);
      clr = '0;
      chk(dma, '0);
      wr(p*8+6, 3'h1, 2'h0, 6'h0);
    end
    wr(9, 3'h2, 2'h0, 6'h01);
    wr(9, 3'h5, 2'h0, 6'h00);
    chk(mux[29:27], 3'h2);
    chk(lk, 40'h1 << 9);
    $display("test requests done");
  endtask

  // A one-cycle dip passes on port A but not on filtered port E.
  task automatic t_glitch();
    logic [39:0] seen;
    gf_en = 1'b1;
    seen = '0;
    drv_val = drv_val & ~40'h40_0000_0040;
    cyc(1);
    drv_val = '1;
    repeat (8) begin
      cyc(1);
      seen = seen | ~lvl;
    end
    chk(seen[38], 1'b0);
    chk(seen[6], 1'b1);
    $display("test glitch done");
  endtask

  initial begin
    {wr_en, c_ps, c_pe, c_pf, c_od, c_ds, c_lk, gf_en, pol} = '0;
    {c_pin, c_mux, c_mode, nmi_code, od_cap, nmi_here, clr} = '0;
    mon_in = 1'b1;
    drv_en = '1;
    drv_val = '1;
    cyc(4);
    rst = 1'b0;
    t_reset();
    t_caps();
    t_nmi();
    t_mon();
    t_req();
    t_glitch();
    results();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule
